//--- csd_engine.sv
// Two-channel cycle-stealing transfer engine with an APB register slave.
// Assumes the memory bus answers with memReady and that cpuStall freezes the CPU.
// How it works
// - Two independent channels, each stealing one bus cycle group per transfer.
// - Each accepted request moves exactly one byte or word from source to destination.
// - The engine wins the shared bus over the CPU, stalling it while transferring.
// - Requests come from the software bit, a selected pin edge or the selected peripheral interrupt.
// - Requests ignore every interrupt mask and priority setting.
// - The engine never touches any peripheral interrupt-pending flag.
// - A channel records and serves requests only while its enable bit is one.
// - Requests arriving before service merge into one pending transfer.
// - 1-Mbyte addresses; only one of source or destination may increment.
// - A 16-bit counter allows 64K units per run.
// - Triggers cover pin edges, timers, serial ports, converter and software.
// - Channel zero is granted before channel one when both are pending.
// - Single mode clears enable when the counter underflows.
// - Repeat mode reloads the counter on underflow and carries on.
// - A channel interrupt pulse is raised when its counter underflows.
// - Writing enable zero stops the channel in either mode.
// - First transfer after enabling loads forward pointer and counter.
// - A transfer occupies at least three cycles: grant, read, write.
// - Software request only for bank zero with software code; bit reads zero.
`timescale 1ns/1ps
`default_nettype none

module csd_engine
#(
    parameter int APB_AW = 8
)
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic resetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [csd_pkg::APB_DW-1:0] pwdata,
    output logic [csd_pkg::APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Request sources.
    input wire logic [csd_pkg::PERIPH_W-1:0] periphIrq,
    input wire logic externalIrqPinA,
    input wire logic externalIrqPinB,
    // Shared memory bus master.
    output logic cpuStall,
    output logic memValid,
    output var csd_pkg::csd_mem_req_type memReq,
    input wire logic memReady,
    input wire logic [csd_pkg::DATA_W-1:0] memRdata,
    // Channel underflow events.
    output logic [csd_pkg::CHANNELS-1:0] channelIrq
);
    import csd_pkg::*;

    if (APB_AW < CH_BIT + 1)
    begin : g_aw_check
        $error("APB address too narrow for two channel blocks.");
    end

    csd_select_type select_reg [CHANNELS];
    csd_ctrl_type control_reg [CHANNELS];
    logic [ADDR_W-1:0] sourcePointer_reg [CHANNELS];
    logic [ADDR_W-1:0] destinationPointer_reg [CHANNELS];
    logic [CNT_W-1:0] reload_reg [CHANNELS];
    logic [CNT_W-1:0] count_reg [CHANNELS];
    logic [ADDR_W-1:0] forward_reg [CHANNELS];
    logic [CHANNELS-1:0] fresh_reg;
    logic [CHANNELS-1:0] pending_reg;
    logic [1:0] pinPrev_reg;
    logic [APB_DW-1:0] prdata_reg;
    logic pslverr_reg;
    csd_state_type state_reg;
    logic activeCh_reg;
    logic memValid_reg;
    csd_mem_req_type memReq_reg;
    logic [CHANNELS-1:0] channelIrq_reg;

    logic apbWrite;
    logic apbSetup;
    logic regCh;
    logic [CH_BIT-1:0] regOff;
    logic mapped;
    logic [APB_DW-1:0] readWord;
    logic [1:0] pins;
    logic [CHANNELS-1:0] trigger;
    logic [CHANNELS-1:0] want;
    logic grantAny;
    logic grantCh;
    logic unitDone;
    logic underflow;
    logic [ADDR_W-1:0] srcAddr;
    logic [ADDR_W-1:0] dstAddr;
    logic [ADDR_W-1:0] step;

    // APB decode.
    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pwrite;
    assign regCh = paddr[CH_BIT];
    assign regOff = paddr[CH_BIT-1:0];
    assign mapped = (paddr >> (CH_BIT + 1)) == '0 && regOff <= OFF_FORWARD && regOff[1:0] == 2'b00;
    assign pready = psel && penable;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

    always_comb
    begin
        readWord = '0;
        case (regOff)
            OFF_SELECT:
            begin
                // The software request bit is a strobe and always reads zero.
                readWord[SEL_BANK_BIT] = select_reg[regCh].bank;
                readWord[SEL_CODE_LSB +: CODE_W] = select_reg[regCh].code;
            end
            OFF_CONTROL:
            begin
                readWord[CTL_WORD_BIT] = control_reg[regCh].word;
                readWord[CTL_REPEAT_BIT] = control_reg[regCh].repeatMode;
                readWord[CTL_ENABLE_BIT] = control_reg[regCh].enable;
                readWord[CTL_SRCINC_BIT] = control_reg[regCh].srcInc;
                readWord[CTL_DSTINC_BIT] = control_reg[regCh].dstInc;
                readWord[CTL_PEND_BIT] = pending_reg[regCh];
            end
            OFF_SOURCE: readWord[ADDR_W-1:0] = sourcePointer_reg[regCh];
            OFF_DEST: readWord[ADDR_W-1:0] = destinationPointer_reg[regCh];
            OFF_RELOAD: readWord[CNT_W-1:0] = reload_reg[regCh];
            OFF_COUNT: readWord[CNT_W-1:0] = count_reg[regCh];
            OFF_FORWARD: readWord[ADDR_W-1:0] = forward_reg[regCh];
            default: readWord = '0;
        endcase
    end

    // Read data is captured in the setup phase so the access phase needs no wait.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prdata_reg <= '0;
            pslverr_reg <= 1'b0;
        end
        else if (apbSetup)
        begin
            prdata_reg <= mapped && !pwrite ? readWord : '0;
            pslverr_reg <= !mapped;
        end
    end

    // Plain configuration registers.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int c = 0; c < CHANNELS; c++)
            begin
                select_reg[c] <= SELECT_RESET;
                sourcePointer_reg[c] <= '0;
                destinationPointer_reg[c] <= '0;
                reload_reg[c] <= '0;
            end
        end
        else if (apbWrite && mapped)
        begin
            case (regOff)
                OFF_SELECT:
                begin
                    select_reg[regCh].bank <= pwdata[SEL_BANK_BIT];
                    select_reg[regCh].code <= pwdata[SEL_CODE_LSB +: CODE_W];
                end
                OFF_SOURCE: sourcePointer_reg[regCh] <= pwdata[ADDR_W-1:0];
                OFF_DEST: destinationPointer_reg[regCh] <= pwdata[ADDR_W-1:0];
                OFF_RELOAD: reload_reg[regCh] <= pwdata[CNT_W-1:0];
                default: ;
            endcase
        end
    end

    // Request sources: pin edges, peripheral lines, software strobe.
    // Interrupt masks never reach this logic, and nothing here drives a pending flag back.
    assign pins = {externalIrqPinB, externalIrqPinA};

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        // Pins rest high, so the history starts high and reset fakes no edge.
        if (!resetn)
            pinPrev_reg <= '1;
        else
            pinPrev_reg <= pins;
    end

    always_comb
    begin
        for (int c = 0; c < CHANNELS; c++)
        begin
            trigger[c] = 1'b0;
            if (!select_reg[c].bank)
            begin
                if (select_reg[c].code == CODE_SOFTWARE)
                    trigger[c] = apbWrite && mapped && regCh == c && regOff == OFF_SELECT
                        && pwdata[SEL_SWREQ_BIT] && !pwdata[SEL_BANK_BIT]
                        && pwdata[SEL_CODE_LSB +: CODE_W] == CODE_SOFTWARE;
                else if (select_reg[c].code == CODE_PIN_FALL)
                    trigger[c] = pinPrev_reg[c] && !pins[c];
                else
                    trigger[c] = periphIrq[select_reg[c].code];
            end
            else if (select_reg[c].code == CODE_PIN_BOTH)
                trigger[c] = pinPrev_reg[c] != pins[c];
        end
    end

    // Arbitration and transfer sequencing.
    always_comb
    begin
        for (int c = 0; c < CHANNELS; c++)
            want[c] = pending_reg[c] && control_reg[c].enable;
    end

    assign grantAny = state_reg == ST_IDLE && want != '0;
    assign grantCh = !want[0];
    assign unitDone = state_reg == ST_WRITE && memReady;
    assign underflow = unitDone && count_reg[activeCh_reg] == CNT_ZERO;
    assign step = control_reg[activeCh_reg].word ? STEP_WORD : STEP_BYTE;
    // Should software set both increment bits, the source alone advances.
    assign srcAddr = control_reg[activeCh_reg].srcInc ? forward_reg[activeCh_reg]
        : sourcePointer_reg[activeCh_reg];
    assign dstAddr = control_reg[activeCh_reg].dstInc && !control_reg[activeCh_reg].srcInc
        ? forward_reg[activeCh_reg] : destinationPointer_reg[activeCh_reg];

    // One flag per channel, so a burst of triggers collapses into one transfer.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            pending_reg <= '0;
        else
        begin
            for (int c = 0; c < CHANNELS; c++)
            begin
                if (trigger[c] && control_reg[c].enable)
                    pending_reg[c] <= 1'b1;
                else if ((grantAny && grantCh == c) || !control_reg[c].enable)
                    pending_reg[c] <= 1'b0;
            end
        end
    end

    // Enable and first-transfer marker; a software write beats the hardware stop.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int c = 0; c < CHANNELS; c++)
                control_reg[c] <= CTRL_RESET;
            fresh_reg <= '0;
        end
        else
        begin
            for (int c = 0; c < CHANNELS; c++)
            begin
                if (apbWrite && mapped && regCh == c && regOff == OFF_CONTROL)
                begin
                    control_reg[c].word <= pwdata[CTL_WORD_BIT];
                    control_reg[c].repeatMode <= pwdata[CTL_REPEAT_BIT];
                    control_reg[c].enable <= pwdata[CTL_ENABLE_BIT];
                    control_reg[c].srcInc <= pwdata[CTL_SRCINC_BIT];
                    control_reg[c].dstInc <= pwdata[CTL_DSTINC_BIT];
                    if (pwdata[CTL_ENABLE_BIT] && !control_reg[c].enable)
                        fresh_reg[c] <= 1'b1;
                end
                else
                begin
                    if (underflow && activeCh_reg == c && !control_reg[c].repeatMode)
                        control_reg[c].enable <= 1'b0;
                    if (grantAny && grantCh == c)
                        fresh_reg[c] <= 1'b0;
                end
            end
        end
    end

    // Bus ownership sequence: grant, read, write; the CPU waits throughout.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= ST_IDLE;
            activeCh_reg <= 1'b0;
            memValid_reg <= 1'b0;
            memReq_reg <= '0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                    if (grantAny)
                    begin
                        activeCh_reg <= grantCh;
                        state_reg <= ST_GRANT;
                    end
                ST_GRANT:
                begin
                    memReq_reg <= '{addr: srcAddr, write: 1'b0,
                        word: control_reg[activeCh_reg].word, wdata: '0};
                    memValid_reg <= 1'b1;
                    state_reg <= ST_READ;
                end
                ST_READ:
                    if (memReady)
                    begin
                        memReq_reg <= '{addr: dstAddr, write: 1'b1,
                            word: memReq_reg.word, wdata: memRdata};
                        state_reg <= ST_WRITE;
                    end
                ST_WRITE:
                    if (memReady)
                    begin
                        memValid_reg <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Forward pointer and counter; loaded on grant of a fresh run, stepped per unit.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int c = 0; c < CHANNELS; c++)
            begin
                forward_reg[c] <= '0;
                count_reg[c] <= '0;
            end
        end
        else if (grantAny && fresh_reg[grantCh])
        begin
            forward_reg[grantCh] <= control_reg[grantCh].srcInc ? sourcePointer_reg[grantCh]
                : destinationPointer_reg[grantCh];
            count_reg[grantCh] <= reload_reg[grantCh];
        end
        else if (unitDone)
        begin
            if (control_reg[activeCh_reg].srcInc || control_reg[activeCh_reg].dstInc)
                forward_reg[activeCh_reg] <= forward_reg[activeCh_reg] + step;
            if (underflow)
                count_reg[activeCh_reg] <= reload_reg[activeCh_reg];
            else
                count_reg[activeCh_reg] <= count_reg[activeCh_reg] - CNT_ONE;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            channelIrq_reg <= '0;
        else
        begin
            for (int c = 0; c < CHANNELS; c++)
                channelIrq_reg[c] <= underflow && activeCh_reg == c;
        end
    end

    assign cpuStall = state_reg != ST_IDLE;
    assign memValid = memValid_reg;
    assign memReq = memReq_reg;
    assign channelIrq = channelIrq_reg;

    // Checks.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_grant;
        grantAny;
    endsequence

    sequence s_no_done_two;
        !unitDone [*2];
    endsequence

    property p_priority;
        state_reg == ST_IDLE && want == 2'b11 |=> activeCh_reg == 1'b0;
    endproperty
    a_priority: assert property (p_priority) else $error("Channel one beat channel zero.");

    property p_stall;
        s_grant |=> cpuStall until_with (state_reg == ST_WRITE && memReady);
    endproperty
    a_stall: assert property (p_stall) else $error("CPU released during a transfer.");

    property p_min_cycles;
        s_grant |-> ##1 s_no_done_two;
    endproperty
    a_min_cycles: assert property (p_min_cycles) else $error("Transfer shorter than three cycles.");

    property p_irq;
        underflow |=> channelIrq[$past(activeCh_reg)] ##1 channelIrq == '0;
    endproperty
    a_irq: assert property (p_irq) else $error("Underflow pulse missing or stretched.");

    property p_single_stop;
        underflow && !control_reg[activeCh_reg].repeatMode && !apbWrite
            |=> !control_reg[$past(activeCh_reg)].enable;
    endproperty
    a_single_stop: assert property (p_single_stop) else $error("Single run kept enabled.");

    property p_repeat_reload;
        underflow && control_reg[activeCh_reg].repeatMode
            |=> count_reg[$past(activeCh_reg)] == $past(reload_reg[activeCh_reg]);
    endproperty
    a_repeat_reload: assert property (p_repeat_reload) else $error("Repeat reload wrong.");

    property p_fresh_load;
        grantAny && fresh_reg[grantCh] |=> count_reg[activeCh_reg] == $past(reload_reg[grantCh]);
    endproperty
    a_fresh_load: assert property (p_fresh_load) else $error("Counter not loaded on first run.");

    property p_swreq;
        apbWrite && mapped && regOff == OFF_SELECT && pwdata[SEL_SWREQ_BIT]
            && !pwdata[SEL_BANK_BIT] && pwdata[SEL_CODE_LSB +: CODE_W] == CODE_SOFTWARE
            && !select_reg[regCh].bank && select_reg[regCh].code == CODE_SOFTWARE
            && control_reg[regCh].enable |=> pending_reg[$past(regCh)] || cpuStall;
    endproperty
    a_swreq: assert property (p_swreq) else $error("Software request lost.");

    property p_disable;
        apbWrite && mapped && regOff == OFF_CONTROL && !pwdata[CTL_ENABLE_BIT]
            |=> !control_reg[$past(regCh)].enable ##1 !pending_reg[$past(regCh, 2)];
    endproperty
    a_disable: assert property (p_disable) else $error("Channel kept running after stop.");

endmodule

`default_nettype wire

//--- csd_pkg.sv
// Shared constants and types of the two-channel cycle-stealing transfer engine.
// Assumes a 32-bit APB register port and a 1-Mbyte, 16-bit shared memory bus.
package csd_pkg;

    localparam int CHANNELS = 2;
    localparam int ADDR_W = 20;
    localparam int CNT_W = 16;
    localparam int DATA_W = 16;
    localparam int CODE_W = 4;
    localparam int PERIPH_W = 16;
    localparam int APB_DW = 32;

    // Register map: channel selected by one address bit, word offsets below it.
    localparam int CH_BIT = 5;
    localparam logic [CH_BIT-1:0] OFF_SELECT = 5'h00;
    localparam logic [CH_BIT-1:0] OFF_CONTROL = 5'h04;
    localparam logic [CH_BIT-1:0] OFF_SOURCE = 5'h08;
    localparam logic [CH_BIT-1:0] OFF_DEST = 5'h0c;
    localparam logic [CH_BIT-1:0] OFF_RELOAD = 5'h10;
    localparam logic [CH_BIT-1:0] OFF_COUNT = 5'h14;
    localparam logic [CH_BIT-1:0] OFF_FORWARD = 5'h18;

    // Select register fields.
    localparam int SEL_CODE_LSB = 0;
    localparam int SEL_BANK_BIT = 5;
    localparam int SEL_SWREQ_BIT = 7;

    // Control register fields.
    localparam int CTL_WORD_BIT = 0;
    localparam int CTL_REPEAT_BIT = 1;
    localparam int CTL_ENABLE_BIT = 2;
    localparam int CTL_SRCINC_BIT = 3;
    localparam int CTL_DSTINC_BIT = 4;
    localparam int CTL_PEND_BIT = 5;

    // Request source codes.
    localparam logic [CODE_W-1:0] CODE_PIN_FALL = 4'h0;
    localparam logic [CODE_W-1:0] CODE_SOFTWARE = 4'h1;
    localparam logic [CODE_W-1:0] CODE_PIN_BOTH = 4'h6;

    localparam logic [ADDR_W-1:0] STEP_BYTE = 20'h00001;
    localparam logic [ADDR_W-1:0] STEP_WORD = 20'h00002;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam int MIN_XFER_CYCLES = 3;

    typedef struct packed {
        logic bank;
        logic [CODE_W-1:0] code;
    } csd_select_type;

    localparam csd_select_type SELECT_RESET = '{bank: 1'b0, code: 4'h0};

    typedef struct packed {
        logic dstInc;
        logic srcInc;
        logic enable;
        logic repeatMode;
        logic word;
    } csd_ctrl_type;

    localparam csd_ctrl_type CTRL_RESET = '{default: 1'b0};

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic write;
        logic word;
        logic [DATA_W-1:0] wdata;
    } csd_mem_req_type;

    typedef enum {ST_IDLE, ST_GRANT, ST_READ, ST_WRITE} csd_state_type;

endpackage

//--- csd_mem_model.sv
// Behavioural memory on the far side of the shared bus.
// Assumes one request at a time, held by the engine until memReady.
`timescale 1ns/1ps
`default_nettype none
module csd_mem_model
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic resetn,
    // Memory bus.
    input wire logic memValid,
    input wire csd_pkg::csd_mem_req_type memReq,
    input wire logic slow,
    output logic memReady,
    output logic [csd_pkg::DATA_W-1:0] memRdata,
    // Record of the latest write.
    output logic [csd_pkg::ADDR_W-1:0] lastAddr,
    output logic [csd_pkg::DATA_W-1:0] lastData,
    output var int writes
);
    import csd_pkg::*;
    logic [1:0] waitCnt;
    logic [15:0] idlePat;
    // Slow mode answers on the third cycle to stretch the stolen slot.
    assign memReady = memValid && (!slow || waitCnt == 2'h2);
    // Data seen outside a read changes every cycle, so a stale sample shows.
    assign memRdata = (memReady && !memReq.write) ? memReq.addr[15:0] ^ 16'ha5c3 : idlePat;
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            waitCnt <= 2'h0;
            idlePat <= 16'h3c3c;
            writes <= 0;
            lastAddr <= '0;
            lastData <= '0;
        end
        else
        begin
            idlePat <= ~idlePat;
            waitCnt <= (memValid && !memReady) ? waitCnt + 2'h1 : 2'h0;
            if (memValid && memReady && memReq.write)
            begin
                writes <= writes + 1;
                lastAddr <= memReq.addr;
                lastData <= memReq.wdata;
            end
        end
    end
endmodule
`default_nettype wire

//--- two_channel_cycle_steal_dma_bench.sv
// Self-checking bench of the transfer engine over APB.
// Assumes the package, the engine and the memory model compile first.
`timescale 1ns/1ps
`default_nettype none
module two_channel_cycle_steal_dma_bench;
    import csd_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] periphIrq = 16'h0;
    logic pinA = 1'b1;
    logic pinB = 1'b1;
    logic slow = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cpuStall;
    logic memValid;
    logic memReady;
    csd_mem_req_type memReq;
    logic [15:0] memRdata;
    logic [1:0] channelIrq;
    logic [19:0] lastAddr;
    logic [15:0] lastData;
    int writes;
    int irq1 = 0;
    int irq0 = 0;
    int error_cnt = 0;
    int comparisons = 0;
    int n;
    logic [31:0] rd;
    logic err;
    always #10 ref_clk = ~ref_clk;
    csd_engine uut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periphIrq(periphIrq), .externalIrqPinA(pinA),
        .externalIrqPinB(pinB), .cpuStall(cpuStall), .memValid(memValid), .memReq(memReq),
        .memReady(memReady), .memRdata(memRdata), .channelIrq(channelIrq));
    csd_mem_model mem (.ref_clk(ref_clk), .resetn(resetn), .memValid(memValid),
        .memReq(memReq), .slow(slow), .memReady(memReady), .memRdata(memRdata),
        .lastAddr(lastAddr), .lastData(lastData), .writes(writes));
    always @(posedge ref_clk)
    begin
        if (channelIrq[0] === 1'b1) irq0 <= irq0 + 1;
        if (channelIrq[1] === 1'b1) irq1 <= irq1 + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp) error_cnt++;
    endtask
    // Idle cycle after each transfer keeps a stale setup from being seen.
    task automatic apb(input logic w, input logic ch, input logic [4:0] off, input int d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, ch, off};
        pwdata <= 32'(d);
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic pulse(input logic [15:0] b, input int k);
        periphIrq <= b;
        repeat (k) @(posedge ref_clk);
        periphIrq <= 16'h0;
        @(posedge ref_clk);
    endtask
    task automatic waitw(input int k);
        for (int i = 0; i < 60 && writes < k; i++) @(posedge ref_clk);
        repeat (3) @(posedge ref_clk);
        chk(32'(writes), 32'(k));
    endtask
    function automatic logic [15:0] rv(input logic [19:0] a);
        return a[15:0] ^ 16'ha5c3;
    endfunction
    task automatic t_reset;
        apb(0, 1, OFF_CONTROL, 0);
        chk(rd, 0);
        apb(0, 0, OFF_SELECT, 0);
        chk(rd, 0);
        apb(0, 1, 5'h1c, 0);
        chk({rd[30:0], err}, 1);
    endtask
    task automatic t_soft;
        apb(1, 0, OFF_SOURCE, 'h12340);
        apb(1, 0, OFF_DEST, 'h00800);
        apb(1, 0, OFF_RELOAD, 1);
        apb(1, 0, OFF_SELECT, 1);
        apb(1, 0, OFF_CONTROL, 'h0d);
        for (int k = 0; k < 2; k++)
        begin
            n = writes + 1;
            apb(1, 0, OFF_SELECT, 'h81);
            waitw(n);
            chk(32'(lastAddr), 'h00800);
            chk(32'(lastData), 32'(rv(20'h12340 + 20'(2 * k))));
            chk(32'(cpuStall), 0);
            chk(32'(memValid), 0);
        end
        apb(0, 0, OFF_FORWARD, 0);
        chk(rd, 'h12344);
        chk(irq0, 1);
        apb(0, 0, OFF_SELECT, 0);
        chk(rd, 1);
        apb(0, 0, OFF_CONTROL, 0);
        chk(rd, 'h09);
        apb(1, 0, OFF_SELECT, 'h81);
        waitw(n);
    endtask
    task automatic t_repeat;
        slow <= 1'b1;
        apb(1, 1, OFF_SOURCE, 'h0abcd);
        apb(1, 1, OFF_DEST, 'h20000);
        apb(1, 1, OFF_RELOAD, 0);
        apb(1, 1, OFF_SELECT, 2);
        apb(1, 1, OFF_CONTROL, 'h16);
        for (int k = 0; k < 3; k++)
        begin
            n = writes + 1;
            pulse(16'h0004, 1);
            waitw(n);
            chk(32'(lastAddr), 32'h20000 + k);
            chk(32'(lastData[7:0]), 32'(rv(20'h0abcd) & 16'h00ff));
        end
        chk(irq1, 3);
        pulse(16'h0004, 4);
        waitw(n + 2);
        apb(1, 1, OFF_CONTROL, 'h12);
        pulse(16'h0004, 1);
        waitw(n + 2);
    endtask
    task automatic t_prio;
        apb(1, 0, OFF_SELECT, 3);
        apb(1, 0, OFF_DEST, 'h00100);
        apb(1, 0, OFF_CONTROL, 'h07);
        apb(1, 1, OFF_CONTROL, 'h16);
        n = writes;
        pulse(16'h000c, 1);
        waitw(n + 1);
        chk(32'(lastAddr), 'h00100);
        apb(0, 0, OFF_COUNT, 0);
        chk(rd, 0);
        waitw(n + 2);
        chk(32'(lastAddr), 'h20000);
        apb(1, 0, OFF_SELECT, 0);
        pinA <= 1'b0;
        waitw(n + 3);
        chk(32'(lastAddr), 'h00100);
        apb(1, 1, OFF_SELECT, 'h26);
        pinB <= 1'b0;
        waitw(n + 4);
        chk(32'(lastAddr), 'h20001);
        pinB <= 1'b1;
        waitw(n + 5);
        chk(32'(lastAddr), 'h20002);
    endtask
    task automatic close_out;
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_soft();
        t_repeat();
        t_prio();
        close_out();
    end
    // Ten thousand cycles cover every scenario many times over.
    initial
    begin
        #200000;
        error_cnt++;
        close_out();
    end
endmodule
`default_nettype wire
